/* File: src/pwm_clk_consts.vh */
// constants for the pwm clock prescaler, chop clock and master duty block
// Behaviour
// - prescale codes 0..6 divide by 1..64, 7 reserved
// - prescale select resets to zero, undivided clock
// - chop generator runs only while bit 15 set
// - chop rate is prescaled rate over divider+1
// - unused register bits ignore writes, read zero
// - sixteen-bit master duty register, cleared at reset
`ifndef PWM_CLK_CONSTS_VH
`define PWM_CLK_CONSTS_VH

// register byte offsets
`define OFS_PRESCALE 12'h000
`define OFS_CHOP 12'h004
`define OFS_MDC 12'h008
`define OFS_CONTROL 12'h00C
`define OFS_STATUS 12'h010

// field positions and masks
`define PRESCALE_MASK 16'h0007
`define CHOP_MASK 16'h83FF
`define CHOP_EN_BIT 15
`define CTRL_MASK 16'h0001
`define PRESCALE_RESERVED 3'h7

// reset values
`define PRESCALE_RST 3'h0
`define CHOP_RST 16'h0000
`define MDC_RST 16'h0000
`define CTRL_RST 1'b0

`endif

/* File: src/pwm_clock_prescale_and_chop.v */
// apb register block with pwm prescaler, chop clock and master duty
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_clk_consts.vh"

module pwm_clock_prescale_and_chop (
	input wire clk,
	input wire resetn,
	input wire ce,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg pwm_tick,
	output reg chop_clk,
	output reg [15:0] master_duty,
	output reg pwm_module_enable
);

reg [2:0] pwm_clock_prescale_sel_q;
reg chop_generator_enable_q;
reg [9:0] chop_divider_value_q;
reg [9:0] chop_cnt_q;
reg [31:0] rdata_d;
reg hit_d;
wire tick_w;
wire acc;
wire wr;

assign acc = psel & penable & ~pready;
assign wr = acc & pwrite;

////////////////////////////////////////////////////////////////////////////////
// prescaler instance
pwm_prescaler u_pre (
	.clk(clk),
	.resetn(resetn),
	.ce(ce),
	.sel(pwm_clock_prescale_sel_q),
	.tick(tick_w)
);

////////////////////////////////////////////////////////////////////////////////
// read mux; unused bits come back zero
always @* begin
	rdata_d = 32'h00000000;
	hit_d = 1'b1;
	if (paddr == `OFS_PRESCALE) begin
		rdata_d = {29'h0, pwm_clock_prescale_sel_q};
	end else if (paddr == `OFS_CHOP) begin
		rdata_d = {16'h0, chop_generator_enable_q, 5'h00, chop_divider_value_q};
	end else if (paddr == `OFS_MDC) begin
		rdata_d = {16'h0, master_duty};
	end else if (paddr == `OFS_CONTROL) begin
		rdata_d = {31'h0, pwm_module_enable};
	end else if (paddr == `OFS_STATUS) begin
		rdata_d = {30'h0, chop_clk, pwm_tick};
	end else begin
		hit_d = 1'b0;
	end
end

// apb slave: one wait state, answer on the cycle after access begins
always @(posedge clk or negedge resetn) begin
	if (!resetn) begin
		pready <= 1'b0;
		pslverr <= 1'b0;
		prdata <= 32'h00000000;
	end else if (ce) begin
		pready <= acc;
		pslverr <= acc & ~hit_d;
		if (acc & ~pwrite) begin
			prdata <= rdata_d;
		end
	end
end

// register writes; only implemented bits are stored
always @(posedge clk or negedge resetn) begin
	if (!resetn) begin
		pwm_clock_prescale_sel_q <= `PRESCALE_RST;
		chop_generator_enable_q <= 1'b0;
		chop_divider_value_q <= 10'h000;
		master_duty <= `MDC_RST;
		pwm_module_enable <= `CTRL_RST;
	end else if (ce && wr) begin
		if (paddr == `OFS_PRESCALE) begin
			pwm_clock_prescale_sel_q <= pwdata[2:0];
		end else if (paddr == `OFS_CHOP) begin
			chop_generator_enable_q <= pwdata[`CHOP_EN_BIT];
			chop_divider_value_q <= pwdata[9:0];
		end else if (paddr == `OFS_MDC) begin
			master_duty <= pwdata[15:0];
		end else if (paddr == `OFS_CONTROL) begin
			pwm_module_enable <= pwdata[0];
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// prescaled tick out, registered
always @(posedge clk or negedge resetn) begin
	if (!resetn) begin
		pwm_tick <= 1'b0;
	end else if (ce) begin
		pwm_tick <= tick_w;
	end
end

// chop counter steps on prescaled ticks; output pulses for one cycle at each
// reload, so one chop period spans divider+1 prescaled ticks even at divider 0
always @(posedge clk or negedge resetn) begin
	if (!resetn) begin
		chop_cnt_q <= 10'h000;
		chop_clk <= 1'b0;
	end else if (ce) begin
		if (!chop_generator_enable_q) begin
			chop_cnt_q <= 10'h000;
			chop_clk <= 1'b0;
		end else if (tick_w) begin
			if (chop_cnt_q >= chop_divider_value_q) begin
				chop_cnt_q <= 10'h000;
				chop_clk <= 1'b1;
			end else begin
				chop_cnt_q <= chop_cnt_q + 10'h001;
				chop_clk <= 1'b0;
			end
		end else begin
			chop_clk <= 1'b0;
		end
	end
end

endmodule // pwm_clock_prescale_and_chop
`default_nettype wire

/* File: src/pwm_prescaler.v */
// prescaler that turns the peripheral clock into a one-cycle tick
`timescale 1ns/1ps
`default_nettype none
`include "pwm_clk_consts.vh"

module pwm_prescaler (
	input wire clk,
	input wire resetn,
	input wire ce,
	input wire [2:0] sel,
	output reg tick
);

reg [5:0] cnt_q;
reg [5:0] limit;

////////////////////////////////////////////////////////////////////////////////
// terminal count per code; reserved code holds the tick low
always @* begin
	case (sel)
		3'h0: limit = 6'h00;
		3'h1: limit = 6'h01;
		3'h2: limit = 6'h03;
		3'h3: limit = 6'h07;
		3'h4: limit = 6'h0F;
		3'h5: limit = 6'h1F;
		default: limit = 6'h3F;
	endcase
end

// free counter; a change of code mid-run may give one odd period
always @(posedge clk or negedge resetn) begin
	if (!resetn) begin
		cnt_q <= 6'h00;
		tick <= 1'b0;
	end else if (ce) begin
		if (sel == `PRESCALE_RESERVED) begin
			cnt_q <= 6'h00;
			tick <= 1'b0;
		end else if (cnt_q >= limit) begin
			cnt_q <= 6'h00;
			tick <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 6'h01;
			tick <= 1'b0;
		end
	end
end

endmodule // pwm_prescaler
`default_nettype wire

/* File: verif/pwm_clk_sva.sv */
// port checker for the pwm prescale and chop block
`timescale 1ns/1ps
`default_nettype none
module pwm_clk_sva (
	input wire clk,
	input wire resetn,
	input wire ce,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pwm_tick,
	input wire chop_clk,
	input wire [15:0] master_duty
);
default clocking @(posedge clk);
endclocking
default disable iff (!resetn);
logic [2:0] sel_q;
logic en_q;
// shadow copies, taken on the block's own write edge so timing lines up
always @(posedge clk or negedge resetn) begin
	if (!resetn) begin
		sel_q <= '0;
		en_q <= 1'b0;
	end else if (ce && psel && penable && !pready && pwrite) begin
		if (paddr == 12'h000) sel_q <= pwdata[2:0];
		if (paddr == 12'h004) en_q <= pwdata[15];
	end
end
////////////////////////////////////////
// read answer at one address
sequence rd(a);
	pready && !pwrite && paddr == a;
endsequence
// tick output lags the select by two registers, so look two cycles back
a_tick_runs: assert property (sel_q == 3'h0 && $past(sel_q) == 3'h0
	&& $past(sel_q, 2) == 3'h0 && $past(pwm_tick) |-> pwm_tick) else $error("tick gap");
a_reserved_still: assert property (sel_q == 3'h7 && $past(sel_q) == 3'h7
	&& $past(sel_q, 2) == 3'h7 |-> !pwm_tick) else $error("tick on reserved");
a_chop_stops: assert property (!en_q && !$past(en_q) |-> !chop_clk)
	else $error("chop runs");
a_chop_on_tick: assert property (chop_clk |-> pwm_tick)
	else $error("chop off tick");
a_presc_unused: assert property (rd(12'h000) |-> prdata[31:3] == '0)
	else $error("prescale bits");
a_chop_unused: assert property (rd(12'h004) |-> (prdata & 32'hFFFF7C00) == '0)
	else $error("chop bits");
a_duty_reads: assert property (rd(12'h008) |-> prdata == {16'h0000, master_duty})
	else $error("duty read");
endmodule // pwm_clk_sva
bind pwm_clock_prescale_and_chop pwm_clk_sva u_sva (.*);
`default_nettype wire

/* File: verif/pwm_clock_prescale_and_chop_bench.sv */
// self-checking bench for the pwm prescale and chop block
`timescale 1ns/1ps
`default_nettype none
module pwm_clock_prescale_and_chop_bench;
logic clk = 0, resetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
logic [11:0] paddr = '0;
logic [31:0] pwdata = '0, prdata, rd;
logic pready, pslverr, pwm_tick, chop_clk, pwm_module_enable, err;
logic [15:0] master_duty;
int bad_count = 0, check_count = 0, cyc = 0, n;
pwm_clock_prescale_and_chop u_pwm_clock_prescale_and_chop (.*);
// clock, and a hang limit well above the run length
initial forever #50 clk = ~clk;
always @(posedge clk) if (++cyc == 20000) begin
	bad_count++;
	finish_test;
end
////////////////////////////////////////
// one transfer; request stands until pready is sampled high
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
	psel <= 1'b1;
	pwrite <= w;
	paddr <= a;
	pwdata <= d;
	@(posedge clk) penable <= 1'b1;
	do @(posedge clk); while (pready !== 1'b1);
	rd = prdata;
	err = pslverr;
	psel <= 1'b0;
	penable <= 1'b0;
	@(posedge clk);
endtask
task chk(input string s, input logic [31:0] e, g);
	check_count++;
	if (g !== e) begin
		bad_count++;
		$display("wrong value %s exp %h got %h", s, e, g);
	end
endtask
task t_regs;
	apb(0, 12'h000, '0);
	chk("presc rst", '0, rd);
	apb(1, 12'h008, 32'hFFFFA5C3);
	chk("duty", 16'hA5C3, master_duty);
	apb(1, 12'h004, 32'hFFFF7FFF);
	apb(0, 12'h004, '0);
	chk("chop", 32'h3FF, rd);
	apb(0, 12'h3FC, '0);
	chk("unmapped", 1'b1, err);
	apb(1, 12'h00C, 32'h1);
	chk("enable", 1'b1, pwm_module_enable);
	// module left disabled so later prescale changes are legal
	apb(1, 12'h00C, 32'h0);
	chk("disable", 1'b0, pwm_module_enable);
endtask
// ticks in a 128-cycle window: every code, reserved one included
task t_presc;
	for (int s = 0; s < 8; s++) begin
		apb(1, 12'h000, s);
		repeat (70) @(posedge clk);
		n = 0;
		repeat (128) @(posedge clk) n += pwm_tick;
		chk("ticks", s < 7 ? 128 >> s : 0, n);
	end
endtask
// chop pulses in 60 cycles at prescale divide-by-one, dividers 0 and 2, then stopped
task t_chop;
	apb(1, 12'h000, 0);
	for (int d = 0; d < 3; d += 2) begin
		apb(1, 12'h004, 32'h8000 | d);
		repeat (9) @(posedge clk);
		n = 0;
		repeat (60) @(posedge clk) n += (chop_clk === 1'b1);
		chk("chop pulses", 60 / (d + 1), n);
	end
	apb(1, 12'h004, 2);
	repeat (3) @(posedge clk);
	chk("chop off", 1'b0, chop_clk);
endtask
task finish_test;
	$display("checks %0d errors %0d", check_count, bad_count);
	if (bad_count == 0 && check_count > 0) $display("TB: PASS");
	else $display("TB: FAIL");
	$finish;
endtask
initial begin
	repeat (20) @(posedge clk);
	resetn <= 1'b1;
	@(posedge clk);
	t_regs;
	t_presc;
	t_chop;
	finish_test;
end
endmodule // pwm_clock_prescale_and_chop_bench
`default_nettype wire
